//--- core/bbm_pkg.sv
// Shared constants and types for the byte and bit move decode block
package bbm_pkg;

  // Clocks per machine cycle, and the range the sequencer can serve
  localparam int MC_CLKS_DEF = 12;
  localparam int MC_CLKS_MIN = 8;
  localparam int MC_CLKS_MAX = 1024;

  // Direct address of the main operand register
  localparam logic [7:0] ACC_ADDR = 8'he0;
  // Upper address bits of the bank registers in direct space
  localparam logic [2:0] REG_HI = 3'h0;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic CY_RST = 1'b0;
  localparam logic [7:0] BIT0_MASK = 8'h01;

  localparam logic [1:0] NB1 = 2'h1;
  localparam logic [1:0] NB2 = 2'h2;
  localparam logic [1:0] NB3 = 2'h3;
  localparam logic [1:0] NC1 = 2'h1;
  localparam logic [1:0] NC2 = 2'h2;

  // Opcodes of the copy_instruction family, select bits shown as zero
  localparam logic [7:0] OPC_A_RN = 8'he8;
  localparam logic [7:0] OPC_A_DIR = 8'he5;
  localparam logic [7:0] OPC_A_IND = 8'he6;
  localparam logic [7:0] OPC_A_IMM = 8'h74;
  localparam logic [7:0] OPC_RN_A = 8'hf8;
  localparam logic [7:0] OPC_RN_DIR = 8'ha8;
  localparam logic [7:0] OPC_RN_IMM = 8'h78;
  localparam logic [7:0] OPC_DIR_A = 8'hf5;
  localparam logic [7:0] OPC_DIR_RN = 8'h88;
  localparam logic [7:0] OPC_DIR_DIR = 8'h85;
  localparam logic [7:0] OPC_DIR_IND = 8'h86;
  localparam logic [7:0] OPC_DIR_IMM = 8'h75;
  localparam logic [7:0] OPC_IND_A = 8'hf6;
  localparam logic [7:0] OPC_IND_DIR = 8'ha6;
  localparam logic [7:0] OPC_IND_IMM = 8'h76;
  localparam logic [7:0] OPC_C_BIT = 8'ha2;
  localparam logic [7:0] OPC_BIT_C = 8'h92;

  typedef enum logic [2:0] {
    OPD_NONE = 3'h0,
    OPD_ACC = 3'h1,
    OPD_REG = 3'h2,
    OPD_DIR = 3'h3,
    OPD_IND = 3'h4,
    OPD_IMM = 3'h5,
    OPD_BIT = 3'h6,
    OPD_CY = 3'h7
  } bbm_opd_e;

  typedef enum logic [1:0] {
    SP_DIR = 2'h0,
    SP_IND = 2'h1,
    SP_BIT = 2'h2
  } bbm_space_e;

  typedef enum logic [6:0] {
    ST_FETCH = 7'h01,
    ST_PTR = 7'h02,
    ST_PTRW = 7'h04,
    ST_RD = 7'h08,
    ST_RDW = 7'h10,
    ST_WR = 7'h20,
    ST_WAIT = 7'h40
  } bbm_state_e;

  typedef struct packed {
    logic legal;
    bbm_opd_e src;
    bbm_opd_e dst;
    logic [1:0] nbytes;
    logic [1:0] ncyc;
  } bbm_dec_s;

  typedef struct packed {
    logic rd;
    logic wr;
    bbm_space_e space;
    logic [7:0] addr;
    logic [7:0] wdata;
  } bbm_mem_s;

endpackage

//--- core/bbm_decode.sv
// Opcode decoder for the byte and bit copy instructions
`timescale 1ns/1ns
module bbm_decode (
  input wire logic [7:0] op_i,
  output bbm_pkg::bbm_dec_s dec_o
);
  import bbm_pkg::*;

  logic [7:0] key;

  // Fold register and pointer select bits so one code names each form
  always_comb begin
    key = op_i;
    if (op_i[3]) begin
      key = {op_i[7:3], 3'h0};
    end else if (op_i[3:1] == 3'h3) begin
      key = {op_i[7:1], 1'b0};
    end
  end

  // Fifteen byte pairings plus the two bit forms
  always_comb begin
    dec_o = '0;
    case (key)
      OPC_A_RN: dec_o = '{1'b1, OPD_REG, OPD_ACC, NB1, NC1};
      OPC_A_DIR: dec_o = '{1'b1, OPD_DIR, OPD_ACC, NB2, NC1};
      OPC_A_IND: dec_o = '{1'b1, OPD_IND, OPD_ACC, NB1, NC1};
      OPC_A_IMM: dec_o = '{1'b1, OPD_IMM, OPD_ACC, NB2, NC1};
      OPC_RN_A: dec_o = '{1'b1, OPD_ACC, OPD_REG, NB1, NC1};
      OPC_RN_DIR: dec_o = '{1'b1, OPD_DIR, OPD_REG, NB2, NC2};
      OPC_RN_IMM: dec_o = '{1'b1, OPD_IMM, OPD_REG, NB2, NC1};
      OPC_DIR_A: dec_o = '{1'b1, OPD_ACC, OPD_DIR, NB2, NC1};
      OPC_DIR_RN: dec_o = '{1'b1, OPD_REG, OPD_DIR, NB2, NC2};
      OPC_DIR_DIR: dec_o = '{1'b1, OPD_DIR, OPD_DIR, NB3, NC2};
      OPC_DIR_IND: dec_o = '{1'b1, OPD_IND, OPD_DIR, NB2, NC2};
      OPC_DIR_IMM: dec_o = '{1'b1, OPD_IMM, OPD_DIR, NB3, NC2};
      OPC_IND_A: dec_o = '{1'b1, OPD_ACC, OPD_IND, NB1, NC1};
      OPC_IND_DIR: dec_o = '{1'b1, OPD_DIR, OPD_IND, NB2, NC2};
      OPC_IND_IMM: dec_o = '{1'b1, OPD_IMM, OPD_IND, NB2, NC1};
      OPC_C_BIT: dec_o = '{1'b1, OPD_BIT, OPD_CY, NB2, NC1};
      OPC_BIT_C: dec_o = '{1'b1, OPD_CY, OPD_BIT, NB2, NC2};
      default: dec_o = '0;
    endcase
  end

endmodule

//--- core/bbm_mc_tick.sv
// Machine-cycle divider: one-cycle tick every CLKS clocks, restartable
`timescale 1ns/1ns
module bbm_mc_tick #(
  parameter int CLKS = bbm_pkg::MC_CLKS_DEF
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clr_i,
  output logic tick_o
);
  localparam int W = $clog2(CLKS);
  localparam logic [W-1:0] LAST = W'(CLKS - 1);

  logic [W-1:0] cnt_q;

  if (CLKS < bbm_pkg::MC_CLKS_MIN || CLKS > bbm_pkg::MC_CLKS_MAX) begin : g_chk
    $error("bbm_mc_tick: CLKS out of range");
  end

  // Restart aligns machine cycles to the opcode fetch
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= '0;
    end else if (clr_i || cnt_q == LAST) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  assign tick_o = (cnt_q == LAST);

endmodule

//--- core/bbm_core.sv
// Byte and bit copy instruction fetch, decode and execute sequencer
// Contract
// - Byte copy writes destination only, no flags
// - Fifteen byte source/destination pairings supported
// - Operand register onto itself is flagged invalid; only 1110 0101 with ACC_ADDR as source is flagged
// - Indirect load: 1110 nibble, one byte, one cycle
// - Immediate load 0111 0100, two bytes, one cycle
// - Store to bank register 1111 1rrr, one cycle
// - Bank register from direct: 1010 1rrr, two cycles
// - Bank register immediate: 0111 1rrr, two bytes
// - Store to direct 1111 0101, one cycle
// - Bank register to direct 1000 1rrr, two cycles
// - Direct to direct: source then destination, three bytes
// - Bit copy uses carry, changes nothing else
// - Carry from bit 1010 0010, one cycle
// - Bit from carry 1001 0010, two cycles
`timescale 1ns/1ns
module bbm_core #(
  parameter int MC_CLKS = bbm_pkg::MC_CLKS_DEF
) (
  input wire logic SYS_CLK_I,
  input wire logic RST_I,
  input wire logic CODE_VALID_I,
  input wire logic [7:0] CODE_BYTE_I,
  input wire logic [1:0] BANK_I,
  input wire logic [7:0] MEM_RDATA_I,
  output logic CODE_READY_O,
  output bbm_pkg::bbm_mem_s MEM_REQ_O,
  output logic [7:0] ACC_O,
  output logic CY_O,
  output logic DONE_O,
  output logic INVALID_O
);
  import bbm_pkg::*;

  bbm_state_e state_q;
  bbm_dec_s dec_in, dec_q, dec_f;
  bbm_mem_s req_q;
  bbm_space_e src_sp, dst_sp;
  logic [7:0] op_q, b1_q, b2_q, ptr_q, val_q, acc_q, acc_start_q;
  logic [7:0] reg_addr, ptr_addr, imm, dst_byte, src_addr, loc_val;
  logic [7:0] dst_addr;
  logic [1:0] cnt_q, mc_cnt_q;
  logic [15:0] clk_q;
  logic ready_q, cy_q, done_q, inv_q, cy_start_q;
  logic mc_tick, take, first, last, retire, bad, need_ptr;
  logic src_rd, dst_mem, dst_acc, dst_cy;

  if (MC_CLKS < MC_CLKS_MIN || MC_CLKS > MC_CLKS_MAX) begin : g_chk
    $error("bbm_core: MC_CLKS out of range");
  end

  // The fetch side needs the byte count before the opcode is registered
  bbm_decode u_dec_in (.op_i(CODE_BYTE_I), .dec_o(dec_in));
  bbm_decode u_dec_q (.op_i(op_q), .dec_o(dec_q));
  bbm_mc_tick #(.CLKS(MC_CLKS)) u_tick (
    .clk_i(SYS_CLK_I),
    .rst_i(RST_I),
    .clr_i(first),
    .tick_o(mc_tick)
  );

  assign dec_f = (cnt_q == 2'h0) ? dec_in : dec_q;
  assign take = CODE_VALID_I && ready_q && (state_q == ST_FETCH);
  assign first = take && (cnt_q == 2'h0);
  assign last = !dec_f.legal || (cnt_q + 2'h1 >= dec_f.nbytes);
  assign need_ptr = (dec_f.src == OPD_IND) || (dec_f.dst == OPD_IND);
  assign retire = (state_q == ST_WAIT) && mc_tick &&
                  ({1'b0, mc_cnt_q} + 3'h1 >= {1'b0, dec_q.ncyc});
  assign bad = (op_q == OPC_A_DIR) && (b1_q == ACC_ADDR);

  // Operand routing from the registered instruction bytes
  always_comb begin
    reg_addr = {REG_HI, BANK_I, op_q[2:0]};
    ptr_addr = {REG_HI, BANK_I, 2'h0, op_q[0]};
    imm = (dec_q.nbytes == NB3) ? b2_q : b1_q;
    dst_byte = (op_q == OPC_DIR_DIR) ? b2_q : b1_q;
    src_rd = 1'b0;
    src_sp = SP_DIR;
    src_addr = b1_q;
    loc_val = acc_q;
    case (dec_q.src)
      OPD_REG: begin
        src_rd = 1'b1;
        src_addr = reg_addr;
      end
      OPD_DIR: src_rd = (b1_q != ACC_ADDR);
      OPD_IND: begin
        src_rd = 1'b1;
        src_sp = SP_IND;
        src_addr = ptr_q;
      end
      OPD_BIT: begin
        src_rd = 1'b1;
        src_sp = SP_BIT;
      end
      OPD_IMM: loc_val = imm;
      OPD_CY: loc_val = {7'h0, cy_q};
      default: loc_val = acc_q;
    endcase
    dst_mem = 1'b0;
    dst_acc = 1'b0;
    dst_cy = 1'b0;
    dst_sp = SP_DIR;
    dst_addr = dst_byte;
    case (dec_q.dst)
      OPD_ACC: dst_acc = 1'b1;
      OPD_REG: begin
        dst_mem = 1'b1;
        dst_addr = reg_addr;
      end
      OPD_DIR: begin
        dst_acc = (dst_byte == ACC_ADDR);
        dst_mem = (dst_byte != ACC_ADDR);
      end
      OPD_IND: begin
        dst_mem = 1'b1;
        dst_sp = SP_IND;
        dst_addr = ptr_q;
      end
      OPD_BIT: begin
        dst_mem = 1'b1;
        dst_sp = SP_BIT;
      end
      OPD_CY: dst_cy = 1'b1;
      default: dst_mem = 1'b0;
    endcase
  end

  // Instruction byte collection; an unknown opcode costs one byte only
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      op_q <= 8'h00;
      b1_q <= 8'h00;
      b2_q <= 8'h00;
      cnt_q <= 2'h0;
      ready_q <= 1'b1;
    end else if (take) begin
      case (cnt_q)
        2'h0: op_q <= CODE_BYTE_I;
        2'h1: b1_q <= CODE_BYTE_I;
        default: b2_q <= CODE_BYTE_I;
      endcase
      cnt_q <= last ? 2'h0 : cnt_q + 2'h1;
      ready_q <= !last || !dec_f.legal;
    end else if (retire) begin
      ready_q <= 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state_q <= ST_FETCH;
    end else begin
      case (state_q)
        ST_FETCH: begin
          if (take && last && dec_f.legal) begin
            state_q <= need_ptr ? ST_PTR : ST_RD;
          end
        end
        ST_PTR: state_q <= ST_PTRW;
        ST_PTRW: state_q <= ST_RD;
        ST_RD: state_q <= ST_RDW;
        ST_RDW: state_q <= ST_WR;
        ST_WR: state_q <= ST_WAIT;
        ST_WAIT: state_q <= retire ? ST_FETCH : ST_WAIT;
        default: state_q <= ST_FETCH;
      endcase
    end
  end

  // Read data is expected in the same cycle the request stands
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ptr_q <= 8'h00;
      val_q <= 8'h00;
    end else if (state_q == ST_PTRW) begin
      ptr_q <= MEM_RDATA_I;
    end else if (state_q == ST_RDW) begin
      if (!src_rd) begin
        val_q <= loc_val;
      end else if (src_sp == SP_BIT) begin
        val_q <= MEM_RDATA_I & BIT0_MASK;
      end else begin
        val_q <= MEM_RDATA_I;
      end
    end
  end

  // Requests are single-cycle pulses; the source is only ever read
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      req_q <= '0;
    end else begin
      req_q <= '0;
      if (state_q == ST_PTR) begin
        req_q.rd <= 1'b1;
        req_q.addr <= ptr_addr;
      end else if (state_q == ST_RD && src_rd) begin
        req_q.rd <= 1'b1;
        req_q.space <= src_sp;
        req_q.addr <= src_addr;
      end else if (state_q == ST_WR && dst_mem && !bad) begin
        req_q.wr <= 1'b1;
        req_q.space <= dst_sp;
        req_q.addr <= dst_addr;
        req_q.wdata <= val_q;
      end
    end
  end

  // Carry moves only for the carry-destination form
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      acc_q <= ACC_RST;
      cy_q <= CY_RST;
    end else if (state_q == ST_WR && !bad) begin
      if (dst_acc) begin
        acc_q <= val_q;
      end
      if (dst_cy) begin
        cy_q <= val_q[0];
      end
    end
  end

  // Completion lands on the ncyc-th machine-cycle tick at the earliest
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      mc_cnt_q <= 2'h0;
    end else if (first) begin
      mc_cnt_q <= 2'h0;
    end else if (mc_tick && mc_cnt_q != NB3) begin
      mc_cnt_q <= mc_cnt_q + 2'h1;
    end
  end

  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      done_q <= 1'b0;
      inv_q <= 1'b0;
    end else begin
      done_q <= retire;
      inv_q <= (take && !dec_f.legal) || (retire && bad);
    end
  end

  assign CODE_READY_O = ready_q;
  assign MEM_REQ_O = req_q;
  assign ACC_O = acc_q;
  assign CY_O = cy_q;
  assign DONE_O = done_q;
  assign INVALID_O = inv_q;

  // Checking helpers: clocks since opcode, state at opcode
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      clk_q <= 16'h0000;
      cy_start_q <= 1'b0;
      acc_start_q <= 8'h00;
    end else if (first) begin
      clk_q <= 16'h0000;
      cy_start_q <= cy_q;
      acc_start_q <= acc_q;
    end else if (clk_q != 16'hffff) begin
      clk_q <= clk_q + 16'h0001;
    end
  end

  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (RST_I);
  property p_imm_acc;
    DONE_O && op_q == OPC_A_IMM |-> ACC_O == b1_q;
  endproperty
  a_imm_acc: assert property (p_imm_acc)
    else $error("immediate load left wrong value");
  property p_flags;
    DONE_O && dec_q.dst != OPD_CY |-> CY_O == cy_start_q;
  endproperty
  a_flags: assert property (p_flags)
    else $error("carry changed by a byte copy");
  property p_mc_time;
    DONE_O |-> clk_q >= 16'(dec_q.ncyc) * 16'(MC_CLKS) &&
               clk_q % 16'(MC_CLKS) == 16'h0000;
  endproperty
  a_mc_time: assert property (p_mc_time)
    else $error("completion off a machine-cycle boundary");
  property p_two_mc;
    DONE_O && op_q[7:3] == OPC_RN_DIR[7:3] |->
      clk_q >= 16'(NC2) * 16'(MC_CLKS);
  endproperty
  a_two_mc: assert property (p_two_mc)
    else $error("two-cycle form finished early");
  property p_acc_self;
    DONE_O && op_q == OPC_A_DIR && b1_q == ACC_ADDR |->
      INVALID_O && ACC_O == acc_start_q;
  endproperty
  a_acc_self: assert property (p_acc_self)
    else $error("self copy not flagged or register changed");
  property p_rn_store;
    MEM_REQ_O.wr && op_q[7:3] == OPC_RN_A[7:3] |->
      MEM_REQ_O.addr[2:0] == op_q[2:0] && MEM_REQ_O.wdata == ACC_O;
  endproperty
  a_rn_store: assert property (p_rn_store)
    else $error("bank register store has wrong target or data");
  property p_ptr_sel;
    MEM_REQ_O.rd && state_q == ST_PTRW |->
      MEM_REQ_O.addr[2:0] == {2'h0, op_q[0]} &&
      MEM_REQ_O.addr[4:3] == BANK_I;
  endproperty
  a_ptr_sel: assert property (p_ptr_sel)
    else $error("pointer register fetch has wrong address");
  // The operand register address is served inside, with no bus access
  property p_dd_move;
    state_q == ST_RDW && op_q == OPC_DIR_DIR && b1_q != ACC_ADDR &&
      b2_q != ACC_ADDR |-> MEM_REQ_O.rd && MEM_REQ_O.addr == b1_q ##2
      MEM_REQ_O.wr && MEM_REQ_O.addr == b2_q &&
      MEM_REQ_O.wdata == $past(MEM_RDATA_I, 2);
  endproperty
  a_dd_move: assert property (p_dd_move)
    else $error("direct to direct copy misrouted");
  property p_cbit;
    state_q == ST_RDW && op_q == OPC_C_BIT |->
      ##2 {7'h0, CY_O} == ($past(MEM_RDATA_I, 2) & BIT0_MASK);
  endproperty
  a_cbit: assert property (p_cbit)
    else $error("carry not loaded from addressed bit");
  property p_bitc;
    MEM_REQ_O.wr && op_q == OPC_BIT_C |->
      MEM_REQ_O.space == SP_BIT && MEM_REQ_O.addr == b1_q &&
      MEM_REQ_O.wdata == {7'h0, CY_O};
  endproperty
  a_bitc: assert property (p_bitc)
    else $error("bit store does not carry the flag");

endmodule

//--- verification/bbm_core_tb.sv
// Self-checking bench for the byte and bit copy sequencer
`timescale 1ns/1ns
module bbm_core_tb;
  import bbm_pkg::*;
  // Shortest machine cycle keeps the run brief
  localparam int MC = 8;
  logic SYS_CLK_I;
  logic RST_I;
  logic CODE_VALID_I;
  logic [7:0] CODE_BYTE_I;
  logic [1:0] BANK_I;
  logic [7:0] MEM_RDATA_I;
  logic CODE_READY_O;
  bbm_mem_s MEM_REQ_O;
  logic [7:0] ACC_O;
  logic CY_O;
  logic DONE_O;
  logic INVALID_O;
  int fail_count = 0;
  int cmp_count = 0;
  int wr_n;
  logic [1:0] w_sp;
  logic [7:0] w_ad;
  logic [7:0] w_da;
  logic [7:0] acc_exp;
  logic cy_exp;

  bbm_core #(.MC_CLKS(MC)) i_dut (
    .SYS_CLK_I(SYS_CLK_I),
    .RST_I(RST_I),
    .CODE_VALID_I(CODE_VALID_I),
    .CODE_BYTE_I(CODE_BYTE_I),
    .BANK_I(BANK_I),
    .MEM_RDATA_I(MEM_RDATA_I),
    .CODE_READY_O(CODE_READY_O),
    .MEM_REQ_O(MEM_REQ_O),
    .ACC_O(ACC_O),
    .CY_O(CY_O),
    .DONE_O(DONE_O),
    .INVALID_O(INVALID_O)
  );

  // Memory contents follow from the address, so no storage is needed
  function automatic logic [7:0] dv(input logic [7:0] a);
    return a ^ 8'h5a;
  endfunction
  function automatic logic [7:0] iv(input logic [7:0] a);
    return a + 8'h33;
  endfunction
  function automatic logic bv(input logic [7:0] a);
    return a[0] ^ a[3];
  endfunction
  function automatic logic [7:0] ra(input int r);
    return {3'h0, BANK_I, 3'(r)};
  endfunction

  // Zero-latency read return, as the memory port expects
  always_comb begin
    case (MEM_REQ_O.space)
      SP_DIR: MEM_RDATA_I = dv(MEM_REQ_O.addr);
      SP_IND: MEM_RDATA_I = iv(MEM_REQ_O.addr);
      default: MEM_RDATA_I = {7'h00, bv(MEM_REQ_O.addr)};
    endcase
  end

  // Mid-cycle sampling avoids racing the registered request
  always @(negedge SYS_CLK_I) begin
    if (RST_I === 1'b0 && MEM_REQ_O.wr === 1'b1) begin
      wr_n = wr_n + 1;
      w_sp = MEM_REQ_O.space;
      w_ad = MEM_REQ_O.addr;
      w_da = MEM_REQ_O.wdata;
    end
  end

  initial begin
    SYS_CLK_I = 1'b0;
    forever #2 SYS_CLK_I = ~SYS_CLK_I;
  end

  task automatic chk_byte(input logic [7:0] got, exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t %s: got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t %s: got %b want %b", $time, what, got, exp);
    end
  endtask
  task automatic chk_num(input int got, exp, input string what);
    cmp_count++;
    if (got != exp) begin
      fail_count++;
      $display("[ERR] %0t %s: got %0d want %0d", $time, what, got, exp);
    end
  endtask

  // Starts at a falling edge; bytes go back to back, as fast as allowed
  task automatic exec(input logic [7:0] b0, b1, b2, input int nb, nc,
      nw, input logic [1:0] sp, input logic [7:0] ad, dt,
      input logic inv);
    logic [7:0] bs [3];
    int k;
    bs = '{b0, b1, b2};
    k = 0;
    for (int i = 0; i < nb; i++) begin
      chk_bit(CODE_READY_O, 1'b1, "ready to take");
      CODE_VALID_I = 1'b1;
      CODE_BYTE_I = bs[i];
      @(posedge SYS_CLK_I);
      if (i == 0) wr_n = 0;
      else k++;
      @(negedge SYS_CLK_I);
    end
    CODE_VALID_I = 1'b0;
    chk_bit(CODE_READY_O, 1'b0, "ready after last byte");
    while (DONE_O !== 1'b1 && k < 4 * MC) begin
      @(posedge SYS_CLK_I);
      k++;
      @(negedge SYS_CLK_I);
    end
    chk_num(k, nc * MC, "cycles to retire");
    chk_bit(CODE_READY_O, 1'b1, "ready with done");
    chk_bit(INVALID_O, inv, "invalid flag");
    chk_num(wr_n, nw, "write count");
    if (nw > 0) begin
      chk_byte({6'h00, w_sp}, {6'h00, sp}, "write space");
      chk_byte(w_ad, ad, "write address");
      chk_byte(w_da, dt, "write data");
    end
    chk_byte(ACC_O, acc_exp, "operand register");
    chk_bit(CY_O, cy_exp, "carry");
  endtask
  task automatic run0(input logic [7:0] b0, b1, input int nb, nc);
    exec(b0, b1, 8'h00, nb, nc, 0, SP_DIR, 8'h00, 8'h00, 1'b0);
  endtask
  task automatic runw(input logic [7:0] b0, b1, b2, input int nb, nc,
      input logic [1:0] sp, input logic [7:0] ad, dt);
    exec(b0, b1, b2, nb, nc, 1, sp, ad, dt, 1'b0);
  endtask

  task automatic t_acc_loads();
    acc_exp = 8'h3c;
    run0(8'h74, 8'h3c, 2, 1);
    for (int r = 0; r < 8; r++) begin
      acc_exp = dv(ra(r));
      run0(8'he8 | 8'(r), 8'h00, 1, 1);
    end
    acc_exp = dv(8'h44);
    run0(8'he5, 8'h44, 2, 1);
    for (int i = 0; i < 2; i++) begin
      acc_exp = iv(dv(ra(i)));
      run0(8'he6 | 8'(i), 8'h00, 1, 1);
    end
    $display("t_acc_loads done");
  endtask

  task automatic t_reg_dst();
    for (int r = 0; r < 8; r++) begin
      runw(8'h78 | 8'(r), 8'h80 + 8'(r), 0, 2, 1, SP_DIR, ra(r),
        8'h80 + 8'(r));
      runw(8'hf8 | 8'(r), 0, 0, 1, 1, SP_DIR, ra(r), acc_exp);
      runw(8'ha8 | 8'(r), 8'h44, 0, 2, 2, SP_DIR, ra(r),
        dv(8'h44));
    end
    $display("t_reg_dst done");
  endtask

  task automatic t_dir_dst();
    runw(8'hf5, 8'h31, 0, 2, 1, SP_DIR, 8'h31, acc_exp);
    runw(8'h8d, 8'h32, 0, 2, 2, SP_DIR, 8'h32, dv(ra(5)));
    runw(8'h85, 8'h45, 8'h46, 3, 2, SP_DIR, 8'h46, dv(8'h45));
    runw(8'h87, 8'h47, 0, 2, 2, SP_DIR, 8'h47, iv(dv(ra(1))));
    runw(8'h75, 8'h48, 8'h9c, 3, 2, SP_DIR, 8'h48, 8'h9c);
    acc_exp = 8'hc3;
    // Direct address of the operand register lands inside, not on the bus
    exec(8'h75, ACC_ADDR, 8'hc3, 3, 2, 0, SP_DIR, 0, 0, 1'b0);
    runw(8'h85, ACC_ADDR, 8'h4a, 3, 2, SP_DIR, 8'h4a, 8'hc3);
    $display("t_dir_dst done");
  endtask

  task automatic t_ind_dst();
    for (int i = 0; i < 2; i++) begin
      runw(8'hf6 | 8'(i), 0, 0, 1, 1, SP_IND, dv(ra(i)), acc_exp);
      runw(8'ha6 | 8'(i), 8'h49, 0, 2, 2, SP_IND, dv(ra(i)),
        dv(8'h49));
      runw(8'h76 | 8'(i), 8'h5e, 0, 2, 1, SP_IND, dv(ra(i)),
        8'h5e);
    end
    $display("t_ind_dst done");
  endtask

  task automatic t_bits();
    cy_exp = bv(8'h08);
    run0(8'ha2, 8'h08, 2, 1);
    runw(8'h92, 8'h20, 0, 2, 2, SP_BIT, 8'h20, {7'h00, cy_exp});
    cy_exp = bv(8'h09);
    run0(8'ha2, 8'h09, 2, 1);
    runw(8'h92, 8'h21, 0, 2, 2, SP_BIT, 8'h21, {7'h00, cy_exp});
    $display("t_bits done");
  endtask

  task automatic t_self();
    exec(8'he5, ACC_ADDR, 0, 2, 1, 0, SP_DIR, 0, 0, 1'b1);
    $display("t_self done");
  endtask

  task automatic t_bad();
    logic seen;
    seen = 1'b0;
    CODE_VALID_I = 1'b1;
    CODE_BYTE_I = 8'ha5;
    @(posedge SYS_CLK_I);
    wr_n = 0;
    @(negedge SYS_CLK_I);
    CODE_VALID_I = 1'b0;
    repeat (3) begin
      chk_bit(CODE_READY_O, 1'b1, "ready after bad opcode");
      chk_bit(DONE_O, 1'b0, "no retire");
      if (INVALID_O === 1'b1) seen = 1'b1;
      @(negedge SYS_CLK_I);
    end
    chk_bit(seen, 1'b1, "bad opcode flagged");
    chk_num(wr_n, 0, "bad opcode writes");
    acc_exp = 8'h6b;
    run0(8'h74, 8'h6b, 2, 1);
    $display("t_bad done");
  endtask

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // About 56 instructions of at most 16 cycles fit well inside this
  initial begin
    #40000;
    fail_count++;
    $display("[ERR] %0t watchdog expired", $time);
    print_verdict();
  end

  initial begin
    RST_I = 1'b1;
    CODE_VALID_I = 1'b0;
    CODE_BYTE_I = 8'h00;
    BANK_I = 2'h2;
    acc_exp = ACC_RST;
    cy_exp = CY_RST;
    wr_n = 0;
    repeat (6) @(posedge SYS_CLK_I);
    @(negedge SYS_CLK_I);
    RST_I = 1'b0;
    chk_bit(CODE_READY_O, 1'b1, "ready out of reset");
    chk_byte(ACC_O, ACC_RST, "operand register reset");
    chk_bit(CY_O, CY_RST, "carry reset");
    chk_bit(DONE_O | INVALID_O, 1'b0, "pulses idle");
    chk_bit(|MEM_REQ_O, 1'b0, "memory idle");
    t_acc_loads();
    BANK_I = 2'h1;
    t_reg_dst();
    BANK_I = 2'h2;
    t_dir_dst();
    t_ind_dst();
    t_bits();
    t_self();
    t_bad();
    print_verdict();
  end
endmodule
